//--- hw/hsv_host_port.sv
// Purpose: vector interrupt register, status register and host bus grant logic
// Assumes: pins are synchronised here; core side inputs are on clk_i
// Notes: avalon-mm slave answers every access one cycle after it arrives
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module hsv_host_port
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_address_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic host_bus_request_n_i,
  input wire logic suspend_bus_tristate_n_i,
  input wire logic [2:0] cluster_position_pins_i,
  input wire logic [1:0] bus_master_id_i,
  input wire logic ext_access_busy_i,
  input wire logic system_access_i,
  input wire logic slave_fifo_push_i,
  input wire logic slave_fifo_drain_i,
  input wire logic pack_partial_i,
  input wire logic core_in_service_i,
  input wire logic core_return_i,
  output logic host_bus_grant_n_o,
  output logic access_suspend_o,
  output logic host_wait_ready_o,
  output logic vector_irq_o,
  output logic [31:0] vector_interrupt_address_o
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] req_sync_ff;
  logic [1:0] sus_sync_ff;
  logic [2:0] pos_meta_ff;
  logic [2:0] pos_ff;
  logic host_req;
  logic host_sus;
  // two stages on every pin, active low pins inverted after the second
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      req_sync_ff <= 2'h3;
      sus_sync_ff <= 2'h3;
      pos_meta_ff <= 3'h0;
      pos_ff <= 3'h0;
    end
    else
    begin
      req_sync_ff <= {req_sync_ff[0], host_bus_request_n_i};
      sus_sync_ff <= {sus_sync_ff[0], suspend_bus_tristate_n_i};
      pos_meta_ff <= cluster_position_pins_i;
      pos_ff <= pos_meta_ff;
    end
  end
  assign host_req = ~req_sync_ff[1];
  assign host_sus = ~sus_sync_ff[1];
  // ************************************************************
  // avalon-mm slave
  // ************************************************************
  hsv_pkg::hsv_req_s req;
  hsv_pkg::hsv_stat_s stat;
  logic pending_ff;
  logic ack;
  logic host_vec_wr;
  logic core_vec_wr;
  logic sync_ff;
  logic [31:0] vec_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] stat_word;
  hsv_pkg::hsv_bus_e bus_ff;
  logic in_service_ff;
  logic vpend_ff;
  logic slave_write_pending_ff;
  assign req = '{avs_read_i, avs_write_i, avs_address_i, avs_writedata_i};
  assign ack = pending_ff & (req.read | req.write);
  assign host_vec_wr = ack & req.write & (req.address == hsv_pkg::ADDR_VECTOR);
  assign core_vec_wr = ack & req.write & (req.address == hsv_pkg::ADDR_CORE_VECTOR);
  // waitrequest drops one cycle after a request appears
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pending_ff <= 1'b0;
    else
      pending_ff <= (req.read | req.write) & ~ack;
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= ~((req.read | req.write) & ~ack);
  end
  // read mux, unmapped reads return zero
  always_comb
  begin
    unique case (req.address)
      hsv_pkg::ADDR_VECTOR: nxt_rdata = vec_ff;
      hsv_pkg::ADDR_CORE_VECTOR: nxt_rdata = vec_ff;
      hsv_pkg::ADDR_STATUS: nxt_rdata = stat_word;
      hsv_pkg::ADDR_CONTROL: nxt_rdata = {31'h0, sync_ff};
      default: nxt_rdata = hsv_pkg::UNMAPPED_DATA;
    endcase
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      avs_readdata_o <= hsv_pkg::UNMAPPED_DATA;
    else if ((req.read | req.write) & ~ack)
      avs_readdata_o <= nxt_rdata;
  end
  // control: arbitration sync flag set by software
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      sync_ff <= 1'b0;
    else if (ack & req.write & (req.address == hsv_pkg::ADDR_CONTROL))
      sync_ff <= req.writedata[hsv_pkg::CT_SYNC];
  end
  // ************************************************************
  // vector interrupt register
  // ************************************************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      in_service_ff <= 1'b0;
    else
      in_service_ff <= core_in_service_i;
  end
  // host write ignored in service; newer write replaces pending one
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      vec_ff <= hsv_pkg::VECTOR_RESET;
    else if (host_vec_wr & ~in_service_ff)
      vec_ff <= req.writedata;
    else if (core_vec_wr)
      vec_ff <= req.writedata;
  end
  // pending flag: set by host write, cleared on return; set wins
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      vpend_ff <= 1'b0;
    else if (host_vec_wr & ~in_service_ff)
      vpend_ff <= 1'b1;
    else if (core_return_i)
      vpend_ff <= 1'b0;
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      vector_irq_o <= 1'b0;
    else
      vector_irq_o <= host_vec_wr & ~in_service_ff;
  end
  assign vector_interrupt_address_o = vec_ff;
  // ************************************************************
  // slave write pending and status word
  // ************************************************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      slave_write_pending_ff <= 1'b0;
    else if (slave_fifo_push_i)
      slave_write_pending_ff <= 1'b1;
    else if (slave_fifo_drain_i)
      slave_write_pending_ff <= 1'b0;
  end
  // ready low while a slave write is pending and not being drained, stalling the host
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      host_wait_ready_o <= 1'b1;
    else
      host_wait_ready_o <= ~(slave_write_pending_ff & ~slave_fifo_drain_i);
  end
  always_comb
  begin
    stat.host_owns_bus = (bus_ff == hsv_pkg::HSV_GRANTED);
    stat.arbitration_synced = sync_ff;
    stat.current_master_code = (pos_ff == hsv_pkg::POS_SINGLE) ?
      hsv_pkg::MASTER_SINGLE : bus_master_id_i;
    stat.pinout_code = pos_ff[1:0];
    stat.slave_write_pending = slave_write_pending_ff;
    stat.vector_irq_pending = vpend_ff;
    stat.host_pack_state = pack_partial_i;
    stat_word = 32'h0;
    stat_word[hsv_pkg::ST_HOST_OWNS] = stat.host_owns_bus;
    stat_word[hsv_pkg::ST_SYNCED] = stat.arbitration_synced;
    stat_word[hsv_pkg::ST_MASTER_LO +: 2] = stat.current_master_code;
    stat_word[hsv_pkg::ST_PINOUT_LO +: 2] = stat.pinout_code;
    stat_word[hsv_pkg::ST_SLAVE_WR] = stat.slave_write_pending;
    stat_word[hsv_pkg::ST_VEC_PEND] = stat.vector_irq_pending;
    stat_word[hsv_pkg::ST_PACK] = stat.host_pack_state;
  end
  // ************************************************************
  // host bus grant handshake
  // ************************************************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      bus_ff <= hsv_pkg::HSV_IDLE;
    else
    begin
      unique case (bus_ff)
        hsv_pkg::HSV_IDLE:
          if (host_req & host_sus & system_access_i)
            bus_ff <= hsv_pkg::HSV_SUSPEND;
          else if (host_req & (ext_access_busy_i | system_access_i))
            bus_ff <= hsv_pkg::HSV_ACCESS;
          else if (host_req)
            bus_ff <= hsv_pkg::HSV_GRANTED;
        hsv_pkg::HSV_ACCESS:
          if (~host_req)
            bus_ff <= hsv_pkg::HSV_IDLE;
          else if (host_sus & system_access_i)
            bus_ff <= hsv_pkg::HSV_SUSPEND;
          else if (~ext_access_busy_i & ~system_access_i)
            bus_ff <= hsv_pkg::HSV_GRANTED;
        hsv_pkg::HSV_SUSPEND:
          bus_ff <= host_req ? hsv_pkg::HSV_GRANTED : hsv_pkg::HSV_IDLE;
        hsv_pkg::HSV_GRANTED:
          if (~host_req)
            bus_ff <= hsv_pkg::HSV_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      host_bus_grant_n_o <= 1'b1;
    else
      host_bus_grant_n_o <= ~(bus_ff == hsv_pkg::HSV_GRANTED & host_req);
  end
  // suspension kept while host holds the bus after a suspend
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      access_suspend_o <= 1'b0;
    else if (bus_ff == hsv_pkg::HSV_SUSPEND)
      access_suspend_o <= 1'b1;
    else if (bus_ff == hsv_pkg::HSV_IDLE)
      access_suspend_o <= 1'b0;
  end
  // ************************************************************
  // checks
  // ************************************************************
  a_core_no_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    core_vec_wr |=> ~vector_irq_o)
    else $error("core vector write raised an interrupt");
  a_service_ignores: assert property (@(posedge clk_i) disable iff (rst_i)
    (host_vec_wr & in_service_ff) |=> (vec_ff == $past(vec_ff)))
    else $error("vector changed during service");
  a_pend_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (host_vec_wr & ~in_service_ff) |=> vpend_ff ##0 vector_irq_o)
    else $error("vector pending not set");
  a_grant_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    (system_access_i & ~host_sus & bus_ff != hsv_pkg::HSV_GRANTED
     & bus_ff != hsv_pkg::HSV_SUSPEND) |=> host_bus_grant_n_o)
    else $error("grant given during own system access");
  a_suspend_grant: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_ff == hsv_pkg::HSV_SUSPEND && host_req) |=> ##1 ~host_bus_grant_n_o)
    else $error("no grant after suspend");
  a_host_owns: assert property (@(posedge clk_i) disable iff (rst_i)
    ~host_bus_grant_n_o |-> $past(stat_word[hsv_pkg::ST_HOST_OWNS]))
    else $error("grant without ownership bit");
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    stat_word[31:15] == 17'h0 && stat_word[11:10] == 2'h0
    && stat_word[7:6] == 2'h0 && stat_word[3:2] == 2'h0)
    else $error("reserved status bits nonzero");
  a_single_master: assert property (@(posedge clk_i) disable iff (rst_i)
    pos_ff == hsv_pkg::POS_SINGLE |-> stat_word[5:4] == hsv_pkg::MASTER_SINGLE)
    else $error("single processor master code wrong");
  a_slave_pend: assert property (@(posedge clk_i) disable iff (rst_i)
    slave_fifo_push_i |=> slave_write_pending_ff)
    else $error("slave write pending not set");
endmodule // hsv_host_port

//--- hw/hsv_pkg.sv
// Purpose: shared constants and carriers for the host status and vector block
// Assumes: 32-bit avalon-mm register bus, word addressed by byte offset
// Notes: register offsets are local choices
package hsv_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [3:0] ADDR_VECTOR = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CORE_VECTOR = 4'h8;
  localparam logic [3:0] ADDR_CONTROL = 4'hc;
  // default vector table address restored by reset
  localparam logic [31:0] VECTOR_RESET = 32'h0000_0040;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // ************************************************************
  // status field positions
  // ************************************************************
  localparam int ST_HOST_OWNS = 0;
  localparam int ST_SYNCED = 1;
  localparam int ST_MASTER_LO = 4;
  localparam int ST_PINOUT_LO = 8;
  localparam int ST_SLAVE_WR = 12;
  localparam int ST_VEC_PEND = 13;
  localparam int ST_PACK = 14;
  localparam logic [1:0] MASTER_SINGLE = 2'h1;
  localparam logic [2:0] POS_SINGLE = 3'h0;
  // control register bit: sync indication from arbitration
  localparam int CT_SYNC = 0;
  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } hsv_req_s;
  typedef struct packed {
    logic host_owns_bus;
    logic arbitration_synced;
    logic [1:0] current_master_code;
    logic [1:0] pinout_code;
    logic slave_write_pending;
    logic vector_irq_pending;
    logic host_pack_state;
  } hsv_stat_s;
  typedef enum logic [1:0] {
    HSV_IDLE,
    HSV_ACCESS,
    HSV_SUSPEND,
    HSV_GRANTED
  } hsv_bus_e;
endpackage

//--- sim/hsv_host_model.sv
// Purpose: host side model that raises the bus request and the suspend pin
// Assumes: both pins active low, driven on clk_i
// Notes: suspend is only raised when the bench commands a deadlock break
`timescale 1ns/100ps
module hsv_host_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic want_i,
  input wire logic force_i,
  input wire logic grant_n_i,
  output logic request_n_o,
  output logic suspend_n_o
);
  logic buffers_on;
  // the grant is what opens the system bus buffers
  assign buffers_on = !grant_n_i;
  // request follows the wish and stays steady for the whole access
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      request_n_o <= 1'b1;
    else
      request_n_o <= !want_i;
  end
  // suspend only beside a request, dropped once the grant arrives
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      suspend_n_o <= 1'b1;
    else
      suspend_n_o <= !(force_i && !request_n_o && !buffers_on);
  end
endmodule // hsv_host_model

//--- sim/tb.sv
// Purpose: self-checking bench for the host status and vector block
// Assumes: slave answers every access after one wait cycle
// Notes: reads are checked by a monitor against a queue of expected words
`timescale 1ns/100ps
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, vec_o, vec, wd;
  logic want = 1'b0, frc = 1'b0, busy = 1'b0, sacc = 1'b0, push = 1'b0, drain = 1'b0;
  logic pack = 1'b0, insvc = 1'b0, ret = 1'b0, waitreq, grant_n, susp, ready, irq, req_n, sus_n;
  logic [2:0] pins = 3'h0;
  logic [1:0] mid = 2'h2;
  logic [31:0] exp_q[$];
  int fail_count = 0;
  int n_compared = 0;
  int irq_n = 0;
  // ************************************************************
  // clock, design and host model
  // ************************************************************
  always #25 clk_i = ~clk_i;
  hsv_host_port DUT (.clk_i(clk_i), .rst_i(rst_i), .avs_read_i(rd), .avs_write_i(wr),
    .avs_address_i(adr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(waitreq), .host_bus_request_n_i(req_n),
    .suspend_bus_tristate_n_i(sus_n), .cluster_position_pins_i(pins), .bus_master_id_i(mid),
    .ext_access_busy_i(busy), .system_access_i(sacc), .slave_fifo_push_i(push),
    .slave_fifo_drain_i(drain), .pack_partial_i(pack), .core_in_service_i(insvc),
    .core_return_i(ret), .host_bus_grant_n_o(grant_n), .access_suspend_o(susp),
    .host_wait_ready_o(ready), .vector_irq_o(irq), .vector_interrupt_address_o(vec_o));
  hsv_host_model host (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .force_i(frc),
    .grant_n_i(grant_n), .request_n_o(req_n), .suspend_n_o(sus_n));
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one avalon access; a read queues its expected word
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [31:0] e);
    if (!w)
      exp_q.push_back(e);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (waitreq !== 1'b0)
      @(posedge clk_i);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
  endtask
  // expected status word built field by field
  function automatic logic [31:0] st(input logic own, input logic syn, input logic sw,
    input logic vp);
    st = {17'h0, pack, vp, sw, 2'h0, pins[1:0], 2'h0, (pins == 3'h0) ? 2'h1 : mid, 2'h0, syn, own};
  endfunction
  task automatic wg(input logic e);
    int n;
    n = 0;
    while (grant_n !== e && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(grant_n), 32'(e));
  endtask
  // monitor: read data at the accepting edge, and interrupt pulses
  always @(posedge clk_i)
  begin
    if (rd === 1'b1 && waitreq === 1'b0 && exp_q.size() > 0)
      chk(rdat, exp_q.pop_front());
    if (irq === 1'b1)
      irq_n++;
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    void'($urandom(32'hed2b5274));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(vec_o, hsv_pkg::VECTOR_RESET);
    chk(32'(ready), 32'h1);
    bus(1'b0, hsv_pkg::ADDR_STATUS, 32'h0, st(0, 0, 0, 0));
    wd = $urandom();
    bus(1'b1, hsv_pkg::ADDR_VECTOR, wd, 32'h0);
    @(posedge clk_i);
    chk(32'(irq_n), 32'h1);
    vec = $urandom();
    bus(1'b1, hsv_pkg::ADDR_VECTOR, vec, 32'h0);
    chk(vec_o, vec);
    bus(1'b0, hsv_pkg::ADDR_STATUS, 32'h0, st(0, 0, 0, 1));
    ret <= 1'b1;
    @(posedge clk_i);
    ret <= 1'b0;
    repeat (2) @(posedge clk_i);
    bus(1'b0, hsv_pkg::ADDR_STATUS, 32'h0, st(0, 0, 0, 0));
    irq_n = 0;
    bus(1'b1, hsv_pkg::ADDR_CORE_VECTOR, wd, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(32'(irq_n), 32'h0);
    chk(vec_o, wd);
    ret <= 1'b1;
    insvc <= 1'b1;
    @(posedge clk_i);
    ret <= 1'b0;
    bus(1'b1, hsv_pkg::ADDR_VECTOR, ~wd, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(vec_o, wd);
    chk(32'(irq_n), 32'h0);
    insvc <= 1'b0;
    bus(1'b1, hsv_pkg::ADDR_CORE_VECTOR, 32'h0, 32'h0);
    bus(1'b0, hsv_pkg::ADDR_VECTOR, 32'h0, 32'h0);
    pins <= 3'($urandom_range(2, 1));
    push <= 1'b1;
    pack <= 1'b1;
    @(posedge clk_i);
    push <= 1'b0;
    bus(1'b1, hsv_pkg::ADDR_CONTROL, 32'h1, 32'h0);
    bus(1'b1, hsv_pkg::ADDR_STATUS, 32'hffffffff, 32'h0);
    repeat (4) @(posedge clk_i);
    bus(1'b0, hsv_pkg::ADDR_STATUS, 32'h0, st(0, 1, 1, 0));
    chk(32'(ready), 32'h0);
    drain <= 1'b1;
    pack <= 1'b0;
    @(posedge clk_i);
    drain <= 1'b0;
    bus(1'b0, hsv_pkg::ADDR_STATUS, 32'h0, st(0, 1, 0, 0));
    bus(1'b0, 4'h2, 32'h0, hsv_pkg::UNMAPPED_DATA);
    busy <= 1'b1;
    want <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(32'(grant_n), 32'h1);
    busy <= 1'b0;
    wg(1'b0);
    bus(1'b0, hsv_pkg::ADDR_STATUS, 32'h0, st(1, 1, 0, 0));
    want <= 1'b0;
    wg(1'b1);
    // host held off by own system access until the suspend pin forces the grant
    sacc <= 1'b1;
    want <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(32'(grant_n), 32'h1);
    frc <= 1'b1;
    wg(1'b0);
    chk(32'(susp), 32'h1);
    frc <= 1'b0;
    want <= 1'b0;
    sacc <= 1'b0;
    wg(1'b1);
    stop_test();
  end
  // watchdog: the whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    stop_test();
  end
endmodule // tb
